// *** src/scmc_params.svh ***
`ifndef SCMC_PARAMS_SVH
`define SCMC_PARAMS_SVH

// Register addresses on the special function register port.
`define SCMC_ADDR_CTRL 8'hd8
`define SCMC_ADDR_STAT 8'hd9

// Control register field positions.
`define SCMC_BIT_SLOW_SRC 7
`define SCMC_BIT_FAST_SRC 6
`define SCMC_BIT_PGATE 4
`define SCMC_BIT_FSTOP 3
`define SCMC_BIT_SELFAST 2
`define SCMC_DIV_HI 1
`define SCMC_DIV_LO 0

// Status register field positions.
`define SCMC_ST_SYS_FAST 4
`define SCMC_ST_PCLK_EN 3
`define SCMC_ST_FAST_RUN 2

// Prescaler codes and the matching counter masks.
`define SCMC_DIV16 2'h0
`define SCMC_DIV4 2'h1
`define SCMC_DIV2 2'h2
`define SCMC_DIV1 2'h3
`define SCMC_MASK16 4'hf
`define SCMC_MASK4 4'h3
`define SCMC_MASK2 4'h1
`define SCMC_MASK1 4'h0

// Reset values.
`define SCMC_RST_DIV 2'h3
`define SCMC_RST_BIT 1'h0
`define SCMC_RST_BYTE 8'h00
`define SCMC_RST_CNT 4'h0

// Prescaler counter: a new ratio takes effect at most this many cycles after a write.
`define SCMC_APPLY_MAX 16
`define SCMC_CNT_W 4
`define SCMC_CNT_WRAP 4'hf
`define SCMC_CNT_ONE 4'h1

`endif

// *** src/scmc_pkg.sv ***
package scmc_pkg;

    // Software-visible control bits.
    typedef struct packed {
        logic slow_source_sel;
        logic fast_source_sel;
        logic idle_periph_clock_gate;
        logic fast_osc_stop;
        logic sysclk_source_sel;
        logic [1:0] sysclk_divider;
    } scmc_ctrl_t;

    // Whole state of the control module.
    typedef struct packed {
        scmc_ctrl_t ctrl;
        logic [1:0] applied_div;
        logic [7:0] rdata;
    } scmc_state_t;

    // Whole state of the prescaler counter.
    typedef struct packed {
        logic [3:0] cnt;
    } scmc_div_state_t;

endpackage

// *** src/scmc_clk_div.sv ***
`timescale 1ns/1ns
`include "scmc_params.svh"

module scmc_clk_div (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Applied ratio code.
    input wire logic [1:0] div_code_in,
    // Enable pulse and ratio boundary.
    output logic tick_out,
    output logic wrap_out
);
    import scmc_pkg::*;

    scmc_div_state_t q;
    scmc_div_state_t d;
    logic [3:0] mask;

    // Translate the code to the counter bits that must all be set for a tick.
    always_comb begin
        unique case (div_code_in)
            `SCMC_DIV16: mask = `SCMC_MASK16;
            `SCMC_DIV4: mask = `SCMC_MASK4;
            `SCMC_DIV2: mask = `SCMC_MASK2;
            `SCMC_DIV1: mask = `SCMC_MASK1;
        endcase
    end

    // Free-running counter; all ratios share its phase, so a switch at the wrap is glitch free.
    always_comb begin
        d = q;
        d.cnt = q.cnt + `SCMC_CNT_ONE;
    end

    // Reset restarts the common phase, so every ratio ticks from a known point.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q.cnt <= `SCMC_RST_CNT;
        end else begin
            q <= d;
        end
    end

    // Tick when the masked counter bits are all ones.
    assign tick_out = ((q.cnt & mask) == mask);
    assign wrap_out = (q.cnt == `SCMC_CNT_WRAP);

endmodule

// *** src/scmc_ctrl.sv ***
`timescale 1ns/1ns
`include "scmc_params.svh"

module scmc_ctrl (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Power mode from the core, same clock.
    input wire logic idle_mode_in,
    // Oscillator and pin control.
    output logic slow_crystal_osc_en_out,
    output logic slow_rc_osc_en_out,
    output logic fast_crystal_osc_en_out,
    output logic fast_rc_osc_en_out,
    output logic xtal_pins_en_out,
    output logic xtal_high_gain_out,
    // System clock control.
    output logic sysclk_fast_out,
    output logic sysclk_tick_out,
    output logic [1:0] sysclk_divider_out,
    output logic periph_clk_en_out
);
    import scmc_pkg::*;

    scmc_state_t q;
    scmc_state_t d;
    logic ctrl_wr;
    logic div_wrap;
    logic fast_run;
    logic [7:0] ctrl_rd;
    logic [7:0] stat_rd;

    // Only a write to the control address touches the control bits.
    assign ctrl_wr = reg_wr_in && (reg_addr_in == `SCMC_ADDR_CTRL);

    // The fast oscillator stops only when asked and the system is idle or not running from it.
    assign fast_run = !(q.ctrl.fast_osc_stop && (idle_mode_in || !q.ctrl.sysclk_source_sel));

    // Readback images; reserved bits read as zero.
    always_comb begin
        ctrl_rd = `SCMC_RST_BYTE;
        ctrl_rd[`SCMC_BIT_SLOW_SRC] = q.ctrl.slow_source_sel;
        ctrl_rd[`SCMC_BIT_FAST_SRC] = q.ctrl.fast_source_sel;
        ctrl_rd[`SCMC_BIT_PGATE] = q.ctrl.idle_periph_clock_gate;
        ctrl_rd[`SCMC_BIT_FSTOP] = q.ctrl.fast_osc_stop;
        ctrl_rd[`SCMC_BIT_SELFAST] = q.ctrl.sysclk_source_sel;
        ctrl_rd[`SCMC_DIV_HI:`SCMC_DIV_LO] = q.ctrl.sysclk_divider;
        stat_rd = `SCMC_RST_BYTE;
        stat_rd[`SCMC_ST_SYS_FAST] = q.ctrl.sysclk_source_sel;
        stat_rd[`SCMC_ST_PCLK_EN] = periph_clk_en_out;
        stat_rd[`SCMC_ST_FAST_RUN] = fast_run;
        stat_rd[`SCMC_DIV_HI:`SCMC_DIV_LO] = q.applied_div;
    end

    // Next state. Each guarded bit is judged against the mode held before the write,
    // so one write cannot both unlock and change a bit.
    always_comb begin
        d = q;
        if (ctrl_wr) begin
            if (q.ctrl.sysclk_source_sel) begin
                d.ctrl.slow_source_sel = reg_wdata_in[`SCMC_BIT_SLOW_SRC];
            end
            if (!q.ctrl.sysclk_source_sel) begin
                d.ctrl.fast_source_sel = reg_wdata_in[`SCMC_BIT_FAST_SRC];
                d.ctrl.fast_osc_stop = reg_wdata_in[`SCMC_BIT_FSTOP];
            end
            if (!q.ctrl.fast_osc_stop) begin
                d.ctrl.sysclk_source_sel = reg_wdata_in[`SCMC_BIT_SELFAST];
            end
            // Unguarded bits always land, even when a guarded bit of the same write is refused.
            d.ctrl.idle_periph_clock_gate = reg_wdata_in[`SCMC_BIT_PGATE];
            d.ctrl.sysclk_divider = reg_wdata_in[`SCMC_DIV_HI:`SCMC_DIV_LO];
        end
        // The written ratio is taken over at the common counter wrap, at most sixteen cycles on.
        if (div_wrap) begin
            d.applied_div = d.ctrl.sysclk_divider;
        end
        // Read data stand for exactly one cycle after the strobe.
        d.rdata = `SCMC_RST_BYTE;
        if (reg_rd_in) begin
            if (reg_addr_in == `SCMC_ADDR_CTRL) begin
                d.rdata = ctrl_rd;
            end else if (reg_addr_in == `SCMC_ADDR_STAT) begin
                d.rdata = stat_rd;
            end
        end
    end

    // Register the whole state; reset restores slow sources, divide-by-one and idle read data.
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q.ctrl.slow_source_sel <= `SCMC_RST_BIT;
            q.ctrl.fast_source_sel <= `SCMC_RST_BIT;
            q.ctrl.idle_periph_clock_gate <= `SCMC_RST_BIT;
            q.ctrl.fast_osc_stop <= `SCMC_RST_BIT;
            q.ctrl.sysclk_source_sel <= `SCMC_RST_BIT;
            q.ctrl.sysclk_divider <= `SCMC_RST_DIV;
            q.applied_div <= `SCMC_RST_DIV;
            q.rdata <= `SCMC_RST_BYTE;
        end else begin
            q <= d;
        end
    end

    // Prescaler counter producing the system clock enable.
    scmc_clk_div u_div (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .div_code_in(q.applied_div),
        .tick_out(sysclk_tick_out),
        .wrap_out(div_wrap)
    );

    // Oscillator selects. Both crystal types share the two crystal pins.
    assign slow_crystal_osc_en_out = q.ctrl.slow_source_sel;
    assign slow_rc_osc_en_out = !q.ctrl.slow_source_sel;
    assign fast_crystal_osc_en_out = q.ctrl.fast_source_sel && fast_run;
    assign fast_rc_osc_en_out = !q.ctrl.fast_source_sel && fast_run;
    assign xtal_pins_en_out = q.ctrl.slow_source_sel || q.ctrl.fast_source_sel;
    assign xtal_high_gain_out = q.ctrl.fast_source_sel;

    // System clock and peripheral gating; the gate saves current only while idle.
    assign sysclk_fast_out = q.ctrl.sysclk_source_sel;
    assign sysclk_divider_out = q.applied_div;
    assign periph_clk_en_out = !(q.ctrl.idle_periph_clock_gate && idle_mode_in);
    assign reg_rdata_out = q.rdata;

    // Checks.
    a_slow_src_lock: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && !q.ctrl.sysclk_source_sel) |=> $stable(slow_crystal_osc_en_out))
        else $error("Slow source changed outside fast mode.");

    a_fast_src_lock: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && q.ctrl.sysclk_source_sel) |=> $stable(xtal_high_gain_out))
        else $error("Fast source changed outside slow mode.");

    a_periph_gate_idle: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && reg_wdata_in[`SCMC_BIT_PGATE]) ##1 idle_mode_in |-> !periph_clk_en_out)
        else $error("Peripheral clocks not gated in idle.");

    a_fast_osc_halt: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (q.ctrl.fast_osc_stop && (idle_mode_in || !sysclk_fast_out))
        |-> !(fast_crystal_osc_en_out || fast_rc_osc_en_out))
        else $error("Fast oscillator running while stopped.");

    a_fstop_lock: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && sysclk_fast_out) |=> $stable(q.ctrl.fast_osc_stop))
        else $error("Fast stop changed in fast mode.");

    a_source_lock: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && q.ctrl.fast_osc_stop) |=> $stable(sysclk_fast_out))
        else $error("Clock source changed while fast stop set.");

    a_div_reset_code: assert property (
        @(posedge clk_in)
        !reset_n_in |=> (sysclk_divider_out == `SCMC_DIV1) && sysclk_tick_out)
        else $error("Prescaler not divide-by-one after reset.");

    a_div16_spacing: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (sysclk_tick_out && sysclk_divider_out == `SCMC_DIV16 && q.ctrl.sysclk_divider == `SCMC_DIV16 && !ctrl_wr)
        |=> !sysclk_tick_out [*8])
        else $error("Divide-by-sixteen tick came too early.");

    a_div_apply_time: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr ##1 (!ctrl_wr) [*8] ##1 (!ctrl_wr) [*7])
        |=> (sysclk_divider_out == q.ctrl.sysclk_divider))
        else $error("New prescaler ratio not applied within sixteen cycles.");

    a_other_bits_land: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        ctrl_wr |=> (q.ctrl.idle_periph_clock_gate == $past(reg_wdata_in[`SCMC_BIT_PGATE]))
        && (q.ctrl.sysclk_divider == $past(reg_wdata_in[`SCMC_DIV_HI:`SCMC_DIV_LO])))
        else $error("Unguarded bits of a write did not land.");

    a_read_ctrl_data: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_addr_in == `SCMC_ADDR_CTRL) |=> (reg_rdata_out == $past(ctrl_rd)))
        else $error("Control readback wrong.");

    // Accepted guarded writes take the written value one cycle later.
    a_slow_src_apply: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && sysclk_fast_out)
        |=> (slow_crystal_osc_en_out == $past(reg_wdata_in[`SCMC_BIT_SLOW_SRC])))
        else $error("Slow source write in fast mode was lost.");

    a_fast_src_apply: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && !sysclk_fast_out)
        |=> (xtal_high_gain_out == $past(reg_wdata_in[`SCMC_BIT_FAST_SRC])))
        else $error("Fast source write in slow mode was lost.");

    a_fstop_apply: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && !sysclk_fast_out)
        |=> (q.ctrl.fast_osc_stop == $past(reg_wdata_in[`SCMC_BIT_FSTOP])))
        else $error("Fast stop write in slow mode was lost.");

    a_source_apply: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_wr && !q.ctrl.fast_osc_stop)
        |=> (sysclk_fast_out == $past(reg_wdata_in[`SCMC_BIT_SELFAST])))
        else $error("Clock source write with fast stop clear was lost.");

    // The peripheral gate and the fast stop act only where the modes allow it; at most one fast oscillator runs.
    a_periph_awake: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !idle_mode_in |-> periph_clk_en_out)
        else $error("Peripheral clocks gated outside idle.");

    a_periph_ungated: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !q.ctrl.idle_periph_clock_gate |-> periph_clk_en_out)
        else $error("Peripheral clocks gated without the gate bit.");

    a_fast_osc_free: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !q.ctrl.fast_osc_stop |-> (fast_crystal_osc_en_out || fast_rc_osc_en_out))
        else $error("Fast oscillator halted without the stop bit.");

    a_fast_osc_single: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !(fast_crystal_osc_en_out && fast_rc_osc_en_out))
        else $error("Both fast oscillators enabled at once.");

    // Crystal pins are claimed whenever either crystal type is chosen.
    a_slow_xtal_pins: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        slow_crystal_osc_en_out |-> xtal_pins_en_out)
        else $error("Slow crystal chosen without crystal pins.");

    a_fast_xtal_pins: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        xtal_high_gain_out |-> xtal_pins_en_out)
        else $error("Fast crystal chosen without crystal pins.");

    a_pins_released: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !(slow_crystal_osc_en_out || xtal_high_gain_out) |-> !xtal_pins_en_out)
        else $error("Crystal pins held with no crystal chosen.");

    // Prescaler tick spacing; a write in the tick cycle may move the ratio, so it is left out.
    a_div1_tick: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (sysclk_divider_out == `SCMC_DIV1) |-> sysclk_tick_out)
        else $error("Divide-by-one tick missing.");

    a_div2_spacing: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (sysclk_tick_out && sysclk_divider_out == `SCMC_DIV2 && q.ctrl.sysclk_divider == `SCMC_DIV2 && !ctrl_wr)
        |=> !sysclk_tick_out ##1 sysclk_tick_out)
        else $error("Divide-by-two ticks not every second cycle.");

    a_div4_spacing: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (sysclk_tick_out && sysclk_divider_out == `SCMC_DIV4 && q.ctrl.sysclk_divider == `SCMC_DIV4 && !ctrl_wr)
        |=> (!sysclk_tick_out) [*3] ##1 sysclk_tick_out)
        else $error("Divide-by-four ticks not every fourth cycle.");

    // The applied ratio moves only at the common counter wrap.
    a_div_hold: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !div_wrap |=> $stable(sysclk_divider_out))
        else $error("Applied ratio changed away from the wrap.");

    a_wrap_applies: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (div_wrap && !ctrl_wr) |=> (sysclk_divider_out == q.ctrl.sysclk_divider))
        else $error("Written ratio not taken over at the wrap.");

    // Register port side effects and reset values.
    a_rdata_idle_zero: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        !reg_rd_in |=> (reg_rdata_out == `SCMC_RST_BYTE))
        else $error("Read data stood longer than one cycle.");

    a_read_stat_data: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (reg_rd_in && reg_addr_in == `SCMC_ADDR_STAT) |=> (reg_rdata_out == $past(stat_rd)))
        else $error("Status readback wrong.");

    a_unmapped_write: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        (reg_wr_in && !ctrl_wr) |=> $stable(q.ctrl))
        else $error("Write to another address changed the control bits.");

    a_reset_sources: assert property (
        @(posedge clk_in)
        !reset_n_in |=> (!sysclk_fast_out && !slow_crystal_osc_en_out && !xtal_pins_en_out))
        else $error("Reset did not select the slow internal sources.");

endmodule

// *** verification/tb_system_clock_mode_control.sv ***
`timescale 1ns/1ns
`include "scmc_params.svh"

module tb_system_clock_mode_control;
    import scmc_pkg::*;

    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic idle_mode_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic sxo, sro, fxo, fro, pins, gain, sfast, tick, pclk;
    logic [1:0] div;
    wire [7:0] outs;
    int failures = 0;
    int checks = 0;
    int n;
    int ratio_tab[4] = '{16, 4, 2, 1};

    // Packing the control outputs lets one compare cover a whole state.
    assign outs = {sxo, sro, fxo, fro, pins, gain, sfast, pclk};

    // The clock toggles every half period of 20 ns.
    always #20 clk_in = ~clk_in;

    scmc_ctrl dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .idle_mode_in(idle_mode_in),
        .slow_crystal_osc_en_out(sxo), .slow_rc_osc_en_out(sro),
        .fast_crystal_osc_en_out(fxo), .fast_rc_osc_en_out(fro),
        .xtal_pins_en_out(pins), .xtal_high_gain_out(gain), .sysclk_fast_out(sfast),
        .sysclk_tick_out(tick), .sysclk_divider_out(div), .periph_clk_en_out(pclk)
    );

    // Compares a seen value with the expected one and counts the outcome.
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // One-cycle write strobe; every task starts just after a rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // Read data are sampled mid-cycle, away from the edge that updates them.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        chk("read data", exp, reg_rdata_out);
        @(posedge clk_in);
    endtask

    // Writes the control register and reads back what was kept.
    task automatic wrd(input logic [7:0] d, input logic [7:0] exp);
        wr(`SCMC_ADDR_CTRL, d);
        rd(`SCMC_ADDR_CTRL, exp);
    endtask

    // A new ratio must land within sixteen cycles, then ticks come once per ratio.
    task automatic presc(input logic [1:0] code, input int ratio);
        wr(`SCMC_ADDR_CTRL, {6'h00, code});
        n = 0;
        @(negedge clk_in);
        while (div !== code && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        chk("apply delay", 8'h01, {7'h00, n <= 16});
        n = 0;
        while (tick !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (tick !== 1'b1 && n < 20);
        chk("tick spacing", ratio[7:0], n[7:0]);
        @(posedge clk_in);
        rd(`SCMC_ADDR_CTRL, {6'h00, code});
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence: reset, prescaler codes, guarded bits and idle gating.
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        rd(`SCMC_ADDR_CTRL, 8'h03);
        chk("outputs", 8'h51, outs);
        chk("divider", 8'h03, {6'h00, div});
        wr(8'hd7, 8'hff);
        rd(8'hd7, 8'h00);
        rd(`SCMC_ADDR_CTRL, 8'h03);
        for (int i = 0; i < 4; i++) presc(i[1:0], ratio_tab[i]);
        wrd(8'h83, 8'h03);
        chk("outputs", 8'h51, outs);
        wrd(8'h43, 8'h43);
        chk("outputs", 8'h6d, outs);
        wrd(8'h47, 8'h47);
        chk("outputs", 8'h6f, outs);
        wrd(8'h8f, 8'hc7);
        chk("outputs", 8'haf, outs);
        wrd(8'hc3, 8'hc3);
        chk("outputs", 8'had, outs);
        wrd(8'hcb, 8'hcb);
        chk("outputs", 8'h8d, outs);
        wrd(8'hcf, 8'hcb);
        chk("outputs", 8'h8d, outs);
        idle_mode_in <= 1'b1;
        @(posedge clk_in);
        chk("outputs", 8'h8d, outs);
        wrd(8'hdb, 8'hdb);
        chk("outputs", 8'h8c, outs);
        idle_mode_in <= 1'b0;
        @(posedge clk_in);
        chk("outputs", 8'h8d, outs);
        rd(`SCMC_ADDR_STAT, 8'h0b);
        report_and_stop();
    end

    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge clk_in);
        failures++;
        report_and_stop();
    end
endmodule
